// ===== acd_pkg.sv
// shared constants of the audio clock detector status block
package acd_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [6:0] IDX_RATIO_HIGH = 7'h5c;
  localparam logic [6:0] IDX_RATIO_LOW = 7'h5d;
  localparam logic [6:0] IDX_FLAGS = 7'h5e;
  localparam logic [6:0] IDX_ERROR_IGNORE = 7'h25;
  localparam logic [6:0] IDX_IRQ_STATUS = 7'h60;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h61;

  // ****************************************************************
  // field positions of the flag register and of the ratio msb
  // ****************************************************************
  localparam int FLAG_MCLK_HALTED = 6;
  localparam int FLAG_PLL_UNLOCKED = 5;
  localparam int FLAG_CLOCKS_MISSING = 4;
  localparam int FLAG_AUTO_SETUP = 3;
  localparam int FLAG_MCLK_INVALID = 2;
  localparam int FLAG_BCLK_INVALID = 1;
  localparam int FLAG_RATE_INVALID = 0;
  localparam int RATIO_MSB_POS = 8;
  localparam int FLAG_COUNT = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [8:0] RESET_RATIO = 9'h000;
  localparam logic [6:0] RESET_FLAGS = 7'h00;
  localparam logic [6:0] RESET_IGNORE = 7'h00;
  localparam logic [6:0] RESET_MASK = 7'h00;
  localparam logic [6:0] RESET_STATUS = 7'h00;

  // ****************************************************************
  // detection thresholds
  // ****************************************************************
  localparam logic [8:0] BCLK_RATIO_MIN = 9'h020;
  localparam logic [8:0] BCLK_RATIO_MAX = 9'h100;
  localparam logic [8:0] FRAME_LOW_LIMIT = 9'h005;
  localparam logic [11:0] MCLK_NOPLL_MIN = 12'h080;
  localparam logic [11:0] MCLK_TOLERANCE = 12'h001;
  localparam logic [15:0] PERIOD_TOLERANCE = 16'h0002;
  localparam int MCLK_RATIO_COUNT = 14;
  localparam logic [13:0][11:0] MCLK_RATIO_TABLE = {
    12'h020, 12'h030, 12'h040, 12'h080, 12'h0c0, 12'h100, 12'h180,
    12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800, 12'hc00};

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int MCLK_HALT_NS = 1000;
  localparam int MCLK_HALT_CYCLES = (MCLK_HALT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int FRAME_MIN_NS = 2500;
  localparam int FRAME_MIN_CYCLES = (FRAME_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int FRAME_MAX_NS = 125000;
  localparam int FRAME_MAX_CYCLES = FRAME_MAX_NS / CLOCK_PERIOD_NS;
  localparam int CLOCKS_MISSING_NS = 250000;
  localparam int CLOCKS_MISSING_CYCLES = CLOCKS_MISSING_NS / CLOCK_PERIOD_NS;

endpackage

// ===== acd_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acd_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } acd_sync_t;

  acd_sync_t st;
  acd_sync_t next_st;

  if (WIDTH < 1) begin : g_bad_width
    $error("acd_pin_sync needs at least one bit");
  end

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.level = (st.s2 & st.s3) | (st.level & ~(st.s2 ^ st.s3));
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// ===== acd_detector.sv
// audio clock detector: ratio counting, validity flags, avalon slave
// Function
// - ratio msb read-only bit 0, rest zero
// - count bit clocks per frame, expose low byte
// - ratio at one bit per frame unreliable
// - bit 6 set while master clock halted
// - bit 5 set when pll unlocked or disabled
// - bit 4 set only when both clocks missing
// - bit 3 set when auto setup impossible
// - bit 2 set when master ratio undetectable
// - frame low five bits or less flags master
// - bit 1 clear only if ratio stable, 32..256
// - bit 0 set when sample rate undetectable
// - all errors ignored clears rate invalid flag
`timescale 1ns/1ps
module acd_detector #(
  parameter int FRAME_MAX_CYCLES = acd_pkg::FRAME_MAX_CYCLES,
  parameter int MISSING_CYCLES = acd_pkg::CLOCKS_MISSING_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic master_clock,
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic pll_locked,
  input wire logic pll_enabled,
  output logic irq
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (FRAME_MAX_CYCLES > 65535 || FRAME_MAX_CYCLES <= acd_pkg::FRAME_MIN_CYCLES) begin : g_bad_f
    $error("FRAME_MAX_CYCLES out of range");
  end
  if (MISSING_CYCLES > 65535 || MISSING_CYCLES < 2) begin : g_bad_m
    $error("MISSING_CYCLES out of range");
  end

  localparam logic [15:0] FRAME_MAX = 16'(FRAME_MAX_CYCLES);
  localparam logic [15:0] FRAME_MIN = 16'(acd_pkg::FRAME_MIN_CYCLES);
  localparam logic [15:0] MISSING_MAX = 16'(MISSING_CYCLES);
  localparam logic [15:0] HALT_MAX = 16'(acd_pkg::MCLK_HALT_CYCLES);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [3:0] pins_q;
    logic [8:0] bit_count;
    logic [8:0] low_count;
    logic [11:0] mclk_count;
    logic [15:0] period_count;
    logic [8:0] ratio;
    logic [8:0] low_len;
    logic [11:0] mclk_ratio;
    logic [15:0] period;
    logic ratio_stable;
    logic period_stable;
    logic frame_lost;
    logic [15:0] halt_count;
    logic [15:0] missing_count;
    logic [6:0] flags;
    logic [6:0] ignore;
    logic [6:0] status;
    logic [6:0] mask;
    logic irq;
  } acd_state_t;

  acd_state_t st;
  acd_state_t next_st;

  logic [3:0] pins;
  logic m_edge;
  logic m_rise;
  logic b_edge;
  logic b_rise;
  logic f_edge;
  logic f_rise;
  logic [6:0] index;
  logic request;
  logic [6:0] raw;
  logic [6:0] events;
  logic [15:0] period_diff;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  acd_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .pin_in({pll_locked, frame_clock, bit_clock, master_clock}),
    .level(pins)
  );

  assign m_edge = pins[0] ^ st.pins_q[0];
  assign m_rise = pins[0] & ~st.pins_q[0];
  assign b_edge = pins[1] ^ st.pins_q[1];
  assign b_rise = pins[1] & ~st.pins_q[1];
  assign f_edge = pins[2] ^ st.pins_q[2];
  assign f_rise = pins[2] & ~st.pins_q[2];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // tolerance of one absorbs sampling jitter of the master clock
  function automatic logic mclk_ratio_ok(input logic [11:0] count);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < acd_pkg::MCLK_RATIO_COUNT; i++) begin
      if (count + acd_pkg::MCLK_TOLERANCE >= acd_pkg::MCLK_RATIO_TABLE[i] &&
          count <= acd_pkg::MCLK_RATIO_TABLE[i] + acd_pkg::MCLK_TOLERANCE) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic [7:0] read_mux(input acd_state_t s, input logic [6:0] idx);
    logic [7:0] value;
    value = 8'h00;
    case (idx)
      acd_pkg::IDX_RATIO_HIGH: value = {7'h00, s.ratio[acd_pkg::RATIO_MSB_POS]};
      acd_pkg::IDX_RATIO_LOW: value = s.ratio[7:0];
      acd_pkg::IDX_FLAGS: value = {1'b0, s.flags};
      acd_pkg::IDX_ERROR_IGNORE: value = {1'b0, s.ignore};
      acd_pkg::IDX_IRQ_STATUS: value = {1'b0, s.status};
      acd_pkg::IDX_IRQ_MASK: value = {1'b0, s.mask};
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  assign index = address[8:2];
  assign request = read | write;
  assign period_diff = (st.period_count > st.period) ? st.period_count - st.period
                                                     : st.period - st.period_count;

  // ****************************************************************
  // raw conditions
  // ****************************************************************
  always_comb begin
    raw = '0;
    // no master edge for the halt time
    raw[acd_pkg::FLAG_MCLK_HALTED] = st.halt_count >= HALT_MAX;
    raw[acd_pkg::FLAG_PLL_UNLOCKED] = ~pll_enabled | ~pins[3];
    raw[acd_pkg::FLAG_CLOCKS_MISSING] = st.missing_count >= MISSING_MAX;
    // master ratio must match a known ratio
    raw[acd_pkg::FLAG_MCLK_INVALID] = raw[acd_pkg::FLAG_MCLK_HALTED] | st.frame_lost |
                                      ~mclk_ratio_ok(st.mclk_ratio) |
                                      (st.low_len <= acd_pkg::FRAME_LOW_LIMIT);
    // one bit per frame gives a meaningless ratio, caught as invalid here
    raw[acd_pkg::FLAG_BCLK_INVALID] = st.frame_lost | ~st.ratio_stable |
                                      (st.ratio < acd_pkg::BCLK_RATIO_MIN) |
                                      (st.ratio > acd_pkg::BCLK_RATIO_MAX);
    // frame period stable and in range
    raw[acd_pkg::FLAG_RATE_INVALID] = st.frame_lost | ~st.period_stable |
                                      (st.period < FRAME_MIN);
    // an over-fast master clock aliases into a wrong ratio and fails here
    raw[acd_pkg::FLAG_AUTO_SETUP] = raw[acd_pkg::FLAG_RATE_INVALID] |
                                    raw[acd_pkg::FLAG_MCLK_INVALID] |
                                    (~pll_enabled & (st.mclk_ratio < acd_pkg::MCLK_NOPLL_MIN));
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    events = '0;
    next_st.pins_q = pins;

    // frame measurement
    if (f_rise) begin
      // latch bit clocks of the finished frame
      next_st.ratio = st.bit_count;
      next_st.ratio_stable = ~st.frame_lost & (st.bit_count == st.ratio);
      next_st.bit_count = {8'h00, b_rise};
      next_st.low_len = st.low_count;
      next_st.low_count = 9'h000;
      next_st.mclk_ratio = st.mclk_count;
      next_st.mclk_count = {11'h000, m_rise};
      next_st.period = st.period_count;
      next_st.period_stable = ~st.frame_lost & (period_diff <= acd_pkg::PERIOD_TOLERANCE);
      next_st.period_count = 16'h0001;
      next_st.frame_lost = 1'b0;
    end else begin
      if (st.bit_count != 9'h1ff) begin
        next_st.bit_count = st.bit_count + {8'h00, b_rise};
      end
      if (st.low_count != 9'h1ff) begin
        next_st.low_count = st.low_count + {8'h00, b_rise & ~pins[2]};
      end
      if (st.mclk_count != 12'hfff) begin
        next_st.mclk_count = st.mclk_count + {11'h000, m_rise};
      end
      if (st.period_count != 16'hffff) begin
        next_st.period_count = st.period_count + 16'h0001;
      end
      // too long without a frame: everything derived from frames is void
      if (st.period_count >= FRAME_MAX) begin
        next_st.frame_lost = 1'b1;
        next_st.ratio_stable = 1'b0;
        next_st.period_stable = 1'b0;
      end
    end

    if (m_edge) begin
      next_st.halt_count = 16'h0000;
    end else if (st.halt_count != 16'hffff) begin
      next_st.halt_count = st.halt_count + 16'h0001;
    end

    // any serial clock edge proves presence
    if (b_edge | f_edge) begin
      next_st.missing_count = 16'h0000;
    end else if (st.missing_count != 16'hffff) begin
      next_st.missing_count = st.missing_count + 16'h0001;
    end

    // flags follow current conditions every cycle
    next_st.flags = raw;
    // rate flag drops when every asserted error is ignored
    if ((raw & ~st.ignore) == 7'h00) begin
      next_st.flags[acd_pkg::FLAG_RATE_INVALID] = 1'b0;
    end

    // interrupt on each flag rising
    events = next_st.flags & ~st.flags;

    // bus slave: one wait state, read data captured on the first cycle
    next_st.ack = request & ~st.ack;
    if (request & ~st.ack) begin
      next_st.rdata = read_mux(st, index);
    end
    if (write & st.ack & byteenable[0]) begin
      case (index)
        acd_pkg::IDX_ERROR_IGNORE: next_st.ignore = writedata[6:0];
        acd_pkg::IDX_IRQ_MASK: next_st.mask = writedata[6:0];
        acd_pkg::IDX_IRQ_STATUS: next_st.status = st.status & ~writedata[6:0];
        default: next_st.ignore = next_st.ignore;
      endcase
    end
    // new events win over a write-one-to-clear in the same cycle
    next_st.status = next_st.status | events;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.ratio <= acd_pkg::RESET_RATIO;
      st.flags <= acd_pkg::RESET_FLAGS;
      st.ignore <= acd_pkg::RESET_IGNORE;
      st.mask <= acd_pkg::RESET_MASK;
      st.status <= acd_pkg::RESET_STATUS;
      st.frame_lost <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign waitrequest = request & ~st.ack;
  assign readdata = {24'h000000, st.rdata};
  assign irq = st.irq;

endmodule

// ===== acd_assertions.sv
// concurrent checks on the ports of the audio clock detector
`timescale 1ns/1ps
module acd_assertions #(
  parameter int FRAME_MAX_CYCLES = 6250,
  parameter int MISSING_CYCLES = 12500
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic master_clock,
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic pll_locked,
  input wire logic pll_enabled,
  input wire logic irq
);
  // ****************
  // quiet counters
  // ****************
  logic [15:0] quiet_sck;
  logic [15:0] quiet_mck;
  logic [2:0] pins_d;
  logic fl_rd;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      quiet_sck <= 16'h0000;
      quiet_mck <= 16'h0000;
      pins_d <= 3'h0;
    end else begin
      pins_d <= {master_clock, bit_clock, frame_clock};
      quiet_sck <= (pins_d[1:0] != {bit_clock, frame_clock}) ? 16'h0000 :
        quiet_sck + 16'(quiet_sck != 16'hffff);
      quiet_mck <= (pins_d[2] != master_clock) ? 16'h0000 :
        quiet_mck + 16'(quiet_mck != 16'hffff);
    end
  end
  assign fl_rd = read && !waitrequest && address[8:2] == acd_pkg::IDX_FLAGS;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence req_start;
    $rose(read || write);
  endsequence
  sequence pll_off;
    !pll_enabled [*4];
  endsequence
  sequence sck_running;
    (quiet_sck < 16'h0005) [*8];
  endsequence
  sequence mck_running;
    (quiet_mck < 16'h0004) [*8];
  endsequence
  one_wait_a: assert property (req_start |-> waitrequest ##1 !waitrequest)
    else $error("request not answered after one wait state");
  ratio_high_a: assert property (read && !waitrequest &&
    address[8:2] == acd_pkg::IDX_RATIO_HIGH |-> readdata[31:1] == 31'h0)
    else $error("ratio high register shows reserved bits");
  ratio_low_a: assert property (read && !waitrequest &&
    address[8:2] == acd_pkg::IDX_RATIO_LOW |-> readdata[31:8] == 24'h0)
    else $error("ratio low register too wide");
  pll_off_a: assert property (pll_off ##1 fl_rd |-> readdata[5])
    else $error("disabled pll not reported unlocked");
  clocks_missing_a: assert property (fl_rd && quiet_sck >= MISSING_CYCLES + 12 |-> readdata[4])
    else $error("silent serial clocks not flagged");
  clocks_present_a: assert property (sck_running ##1 fl_rd |-> !readdata[4])
    else $error("running serial clocks flagged missing");
  mclk_halt_a: assert property (fl_rd && quiet_mck >= 16'h0046 |-> readdata[6])
    else $error("halted master clock not flagged");
  mclk_run_a: assert property (mck_running ##1 fl_rd |-> !readdata[6])
    else $error("running master clock flagged halted");
  irq_fall_a: assert property ($fell(irq) |->
    $past(write && !waitrequest) || $past(write && !waitrequest, 2))
    else $error("interrupt dropped without a write");
endmodule

bind acd_detector acd_assertions #(
  .FRAME_MAX_CYCLES(FRAME_MAX_CYCLES),
  .MISSING_CYCLES(MISSING_CYCLES)
) u_acd_assertions (
  .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .master_clock(master_clock), .bit_clock(bit_clock),
  .frame_clock(frame_clock), .pll_locked(pll_locked), .pll_enabled(pll_enabled), .irq(irq)
);

// ===== acd_source_model.sv
// audio serial source: master, bit and frame clocks
`timescale 1ns/1ps
module acd_source_model (
  input wire logic run,
  input wire logic mclk_on,
  input wire integer bits,
  input wire integer low_bits,
  output logic master_clock,
  output logic bit_clock,
  output logic frame_clock
);
  initial begin
    master_clock = 1'b0;
    #3;
    forever begin
      #40;
      master_clock = mclk_on ? ~master_clock : 1'b0;
    end
  end
  // stopped clocks are tied low, frame edges on falling bit edges
  initial begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    #7;
    forever begin
      if (!run) begin
        frame_clock = 1'b0;
        #80;
      end else begin
        for (int i = 0; i < bits; i++) begin
          frame_clock = (i >= low_bits);
          #80 bit_clock = 1'b1;
          #80 bit_clock = 1'b0;
        end
      end
    end
  end
endmodule

// ===== audio_clock_detector_status_tb_top.sv
// self-checking bench for the audio clock detector status block
`timescale 1ns/1ps
module audio_clock_detector_status_tb_top;
  logic clock, reset_n, read, write, pll_locked, pll_enabled, waitrequest, irq;
  logic master_clock, bit_clock, frame_clock, run, mclk_on;
  logic [8:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  int bits, low_bits, n_fail, n_tests;

  acd_detector #(.FRAME_MAX_CYCLES(3000), .MISSING_CYCLES(1000)) dut (
    .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .master_clock(master_clock), .bit_clock(bit_clock),
    .frame_clock(frame_clock), .pll_locked(pll_locked), .pll_enabled(pll_enabled), .irq(irq));
  acd_source_model src (.run(run), .mclk_on(mclk_on), .bits(bits), .low_bits(low_bits),
    .master_clock(master_clock), .bit_clock(bit_clock), .frame_clock(frame_clock));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************
  // bus and checks
  // ****************
  task automatic results();
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // extra idle edges let event and irq updates land before the next access
  // request held until the edge that samples waitrequest low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    repeat (3) @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check($sformatf("register %h", idx), rd[7:0], exp);
  endtask

  task automatic ichk(input logic exp);
    repeat (3) @(negedge clock);
    check("irq", {7'h00, irq}, {7'h00, exp});
  endtask

  // waits five frames so the ratio is seen stable twice
  task automatic link(input logic r, input int b, input int lo, input logic m);
    run = r;
    bits = b;
    low_bits = lo;
    mclk_on = m;
    repeat (40 * b + 200) @(posedge clock);
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    results();
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 9'h000;
    writedata = 32'h00000000;
    byteenable = 4'h1;
    pll_locked = 1'b0;
    pll_enabled = 1'b0;
    run = 1'b0;
    mclk_on = 1'b0;
    bits = 64;
    low_bits = 32;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (1100) @(posedge clock);
    rchk(acd_pkg::IDX_RATIO_HIGH, 8'h00);
    rchk(acd_pkg::IDX_FLAGS, 8'h7f);
    rchk(acd_pkg::IDX_FLAGS, 8'h7f);
    rchk(acd_pkg::IDX_IRQ_STATUS, 8'h7f);
    ichk(1'b0);
    bus(1'b1, acd_pkg::IDX_IRQ_MASK, 8'h20);
    ichk(1'b1);
    bus(1'b1, acd_pkg::IDX_IRQ_STATUS, 8'h7f);
    ichk(1'b0);
    bus(1'b1, acd_pkg::IDX_ERROR_IGNORE, 8'h7f);
    rchk(acd_pkg::IDX_FLAGS, 8'h7e);
    bus(1'b1, acd_pkg::IDX_ERROR_IGNORE, 8'h00);
    rchk(acd_pkg::IDX_IRQ_STATUS, 8'h01);
    ichk(1'b0);
    bus(1'b1, acd_pkg::IDX_IRQ_STATUS, 8'h01);
    bus(1'b1, acd_pkg::IDX_RATIO_HIGH, 8'hfe);
    rchk(acd_pkg::IDX_RATIO_HIGH, 8'h00);
    rchk(7'h10, 8'h00);
    pll_enabled <= 1'b1;
    pll_locked <= 1'b1;
    link(1'b1, 64, 32, 1'b1);
    rchk(acd_pkg::IDX_RATIO_LOW, 8'h40);
    rchk(acd_pkg::IDX_FLAGS, 8'h00);
    link(1'b1, 256, 128, 1'b1);
    rchk(acd_pkg::IDX_RATIO_HIGH, 8'h01);
    rchk(acd_pkg::IDX_RATIO_LOW, 8'h00);
    rchk(acd_pkg::IDX_FLAGS, 8'h00);
    link(1'b1, 16, 8, 1'b1);
    rchk(acd_pkg::IDX_FLAGS, 8'h02);
    pll_enabled <= 1'b0;
    repeat (4) @(posedge clock);
    rchk(acd_pkg::IDX_FLAGS, 8'h2a);
    pll_enabled <= 1'b1;
    link(1'b1, 64, 5, 1'b1);
    rchk(acd_pkg::IDX_FLAGS, 8'h0c);
    link(1'b1, 64, 6, 1'b1);
    rchk(acd_pkg::IDX_FLAGS, 8'h00);
    link(1'b1, 64, 32, 1'b0);
    rchk(acd_pkg::IDX_FLAGS, 8'h4c);
    pll_locked <= 1'b0;
    link(1'b1, 64, 32, 1'b1);
    rchk(acd_pkg::IDX_FLAGS, 8'h20);
    ichk(1'b1);
    bus(1'b1, acd_pkg::IDX_IRQ_STATUS, 8'h20);
    ichk(1'b0);
    link(1'b1, 64, 64, 1'b1);
    repeat (600) @(posedge clock);
    rchk(acd_pkg::IDX_FLAGS, 8'h2f);
    link(1'b0, 64, 32, 1'b1);
    rchk(acd_pkg::IDX_FLAGS, 8'h3f);
    results();
  end
endmodule
